// [verilog/tmon_consts.svh]
// Register addresses, reset values, field masks and bus constants of the temperature monitor
`ifndef TMON_CONSTS_SVH
`define TMON_CONSTS_SVH

`define TMON_SMB_ADDR 7'h2a
`define TMON_BITS_PER_BYTE 4'h8
`define TMON_BIT_ONE 4'h1
`define TMON_BIT_ZERO 4'h0

`define TMON_A_INT_TEMP 8'h00
`define TMON_A_EXT1_TEMP 8'h01
`define TMON_A_STATUS 8'h02
`define TMON_A_CONFIG 8'h03
`define TMON_A_RATE 8'h04
`define TMON_A_INT_HI 8'h05
`define TMON_A_INT_LO 8'h06
`define TMON_A_E1_HI_INT 8'h07
`define TMON_A_E1_LO_INT 8'h08
`define TMON_A_CONFIG_ALIAS 8'h09
`define TMON_A_RATE_ALIAS 8'h0a
`define TMON_A_INT_HI_ALIAS 8'h0b
`define TMON_A_INT_LO_ALIAS 8'h0c
`define TMON_A_E1_HI_INT_ALIAS 8'h0d
`define TMON_A_E1_LO_INT_ALIAS 8'h0e
`define TMON_A_ONE_UPDATE 8'h0f
`define TMON_A_EXT1_FRAC 8'h10
`define TMON_A_SCRATCH_A 8'h11
`define TMON_A_SCRATCH_B 8'h12
`define TMON_A_E1_HI_FRAC 8'h13
`define TMON_A_E1_LO_FRAC 8'h14
`define TMON_A_E2_HI_INT 8'h15
`define TMON_A_E2_LO_INT 8'h16
`define TMON_A_E2_HI_FRAC 8'h17
`define TMON_A_E2_LO_FRAC 8'h18
`define TMON_A_E1_CRIT 8'h19
`define TMON_A_E2_CRIT 8'h1a
`define TMON_A_FAULT 8'h1b
`define TMON_A_MASK 8'h1f

`define TMON_RST_ZERO 8'h00
`define TMON_RST_CONFIG 8'h80
`define TMON_RST_RATE 8'h06
`define TMON_RST_LIMIT_HI 8'h55

`define TMON_STATUS_USED 8'h9e
`define TMON_FAULT_USED 8'h07
`define TMON_FRAC_ZERO 5'h00

`endif

// [verilog/tmon_pkg.sv]
// Types shared by the temperature monitor register bank
package tmon_pkg;

  typedef enum logic [5:0] {
    TMON_ST_IDLE = 6'b000001,
    TMON_ST_RECV = 6'b000010,
    TMON_ST_ACK = 6'b000100,
    TMON_ST_SEND = 6'b001000,
    TMON_ST_RACK = 6'b010000,
    TMON_ST_SPARE = 6'b100000
  } tmon_state_t;

  typedef enum logic [1:0] {
    TMON_K_ADDR = 2'h0,
    TMON_K_PTR = 2'h1,
    TMON_K_DATA = 2'h2
  } tmon_kind_t;

  typedef struct packed {
    logic valid;
    logic [10:0] int_temp;
    logic [10:0] ext1_temp;
    logic [7:0] status;
    logic [7:0] fault;
  } tmon_meas_t;

  typedef struct packed {
    logic [7:0] general_config;
    logic [7:0] update_rate;
    logic [7:0] internal_high_limit;
    logic [7:0] internal_low_limit;
    logic [7:0] ext1_high_limit_integer;
    logic [7:0] ext1_low_limit_integer;
    logic [7:0] ext1_high_limit_fraction;
    logic [7:0] ext1_low_limit_fraction;
    logic [7:0] ext2_high_limit_integer;
    logic [7:0] ext2_low_limit_integer;
    logic [7:0] ext2_high_limit_fraction;
    logic [7:0] ext2_low_limit_fraction;
    logic [7:0] ext1_critical_limit;
    logic [7:0] ext2_critical_limit;
    logic [7:0] channel_masking;
  } tmon_ctrl_t;

endpackage

// [verilog/tmon_regs.sv]
// Temperature monitor register bank behind an SMBus slave port
// Functional notes
// - Unused bits always read back as zero.
// - All register access goes through SMBus port.
// - Configuration shared at 03h and 09h, reset 80h.
// - Update rate shared at 04h/0Ah, reset 06h.
// - Internal high limit shared 05h/0Bh, reset 55h.
// - Internal low limit shared 06h/0Ch, reset 00h.
// - Ext1 high integer shared 07h/0Dh, reset 55h.
// - Ext1 low integer shared 08h/0Eh, reset 00h.
// - Any write to 0Fh starts one update.
// - Scratch bytes 11h, 12h, reset zero.
// - Fault flags at 1Bh clear on read.
// - Channel mask at 1Fh, reset zero.
// - Critical limits at 19h and 1Ah, reset 55h.
// - Ext1 limit fractions at 13h, 14h.
// - Ext2 limits at 15h through 18h.
// - Results read-only at 00h, 01h, 10h.
// - Status at 02h is read-only, reset zero.
// - Ext1 result eleven bits, fraction left-justified.
// - Integer read latches fraction into shadow.
`timescale 1ns/1ps
`include "tmon_consts.svh"

module tmon_regs
(
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic scl_i, // SMBus clock pin level
  input wire logic sda_i, // SMBus data pin level
  output logic sda_o, // SMBus data drive value, always low
  output logic sda_oe, // SMBus data pull-low enable
  input wire tmon_pkg::tmon_meas_t meas_i, // Measurement results from the converter
  output tmon_pkg::tmon_ctrl_t ctrl_o, // Stored control and limit settings
  output logic one_update_o // One-cycle pulse, start one update
);

  logic scl_s1, scl_s2, scl_q;
  logic sda_s1, sda_s2, sda_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  tmon_pkg::tmon_state_t state_reg;
  tmon_pkg::tmon_kind_t kind_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic rw_reg;
  logic acked_reg;
  logic sda_oe_reg;
  logic sda_o_reg;
  logic wr_stb, rd_stb;
  logic [7:0] rd_data;
  tmon_pkg::tmon_ctrl_t ctrl_reg;
  logic [7:0] scratch_a_reg, scratch_b_reg;
  logic [7:0] res_int_reg, res_ext1_reg, res_frac_reg, shadow_reg;
  logic [7:0] status_reg, fault_reg;
  logic one_update_reg;

  // ---------------------------------------------------------------
  // Pin synchronisers and bus events
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_q <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_q <= 1'b1;
    end
    else if (ce)
    begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_q <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_q <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 & ~scl_q;
  assign scl_fall = ~scl_s2 & scl_q;
  // Data moving while clock is high frames a transfer
  assign bus_start = scl_s2 & scl_q & sda_q & ~sda_s2;
  assign bus_stop = scl_s2 & scl_q & ~sda_q & sda_s2;

  // Register strobes, only ever raised by the bus engine
  assign wr_stb = ce & !bus_start & !bus_stop & (state_reg == tmon_pkg::TMON_ST_RECV) & scl_fall
    & (bit_cnt_reg == `TMON_BITS_PER_BYTE) & (kind_reg == tmon_pkg::TMON_K_DATA);
  assign rd_stb = ce & !bus_start & !bus_stop & scl_fall
    & (((state_reg == tmon_pkg::TMON_ST_ACK) & (kind_reg == tmon_pkg::TMON_K_ADDR) & rw_reg)
    | ((state_reg == tmon_pkg::TMON_ST_RACK) & acked_reg));

  // ---------------------------------------------------------------
  // SMBus slave engine
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= tmon_pkg::TMON_ST_IDLE;
      kind_reg <= tmon_pkg::TMON_K_ADDR;
      bit_cnt_reg <= `TMON_BIT_ZERO;
      rx_reg <= `TMON_RST_ZERO;
      tx_reg <= `TMON_RST_ZERO;
      ptr_reg <= `TMON_RST_ZERO;
      rw_reg <= 1'b0;
      acked_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      sda_o_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (bus_start)
      begin
        state_reg <= tmon_pkg::TMON_ST_RECV;
        kind_reg <= tmon_pkg::TMON_K_ADDR;
        bit_cnt_reg <= `TMON_BIT_ZERO;
        sda_oe_reg <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_reg <= tmon_pkg::TMON_ST_IDLE;
        sda_oe_reg <= 1'b0;
      end
      else
      begin
        case (state_reg)
          tmon_pkg::TMON_ST_RECV:
          begin
            if (scl_rise)
            begin
              rx_reg <= {rx_reg[6:0], sda_s2};
              bit_cnt_reg <= bit_cnt_reg + `TMON_BIT_ONE;
            end
            else if (scl_fall && bit_cnt_reg == `TMON_BITS_PER_BYTE)
            begin
              if (kind_reg == tmon_pkg::TMON_K_ADDR && rx_reg[7:1] != `TMON_SMB_ADDR)
                state_reg <= tmon_pkg::TMON_ST_IDLE;
              else
              begin
                // Writes to any address are acknowledged, even read-only ones
                sda_oe_reg <= 1'b1;
                state_reg <= tmon_pkg::TMON_ST_ACK;
                if (kind_reg == tmon_pkg::TMON_K_ADDR)
                  rw_reg <= rx_reg[0];
                if (kind_reg == tmon_pkg::TMON_K_PTR)
                  ptr_reg <= rx_reg;
              end
            end
          end
          tmon_pkg::TMON_ST_ACK:
          begin
            if (scl_fall)
            begin
              if (kind_reg == tmon_pkg::TMON_K_ADDR && rw_reg)
              begin
                tx_reg <= rd_data;
                sda_oe_reg <= ~rd_data[7];
                bit_cnt_reg <= `TMON_BIT_ONE;
                state_reg <= tmon_pkg::TMON_ST_SEND;
              end
              else
              begin
                sda_oe_reg <= 1'b0;
                bit_cnt_reg <= `TMON_BIT_ZERO;
                state_reg <= tmon_pkg::TMON_ST_RECV;
                kind_reg <= (kind_reg == tmon_pkg::TMON_K_ADDR) ? tmon_pkg::TMON_K_PTR : tmon_pkg::TMON_K_DATA;
              end
            end
          end
          tmon_pkg::TMON_ST_SEND:
          begin
            if (scl_fall)
            begin
              if (bit_cnt_reg == `TMON_BITS_PER_BYTE)
              begin
                sda_oe_reg <= 1'b0;
                state_reg <= tmon_pkg::TMON_ST_RACK;
              end
              else
              begin
                sda_oe_reg <= ~tx_reg[6];
                tx_reg <= {tx_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + `TMON_BIT_ONE;
              end
            end
          end
          tmon_pkg::TMON_ST_RACK:
          begin
            if (scl_rise)
              acked_reg <= ~sda_s2;
            else if (scl_fall)
            begin
              // Host ack asks for the same register once more
              if (acked_reg)
              begin
                tx_reg <= rd_data;
                sda_oe_reg <= ~rd_data[7];
                bit_cnt_reg <= `TMON_BIT_ONE;
                state_reg <= tmon_pkg::TMON_ST_SEND;
              end
              else
                state_reg <= tmon_pkg::TMON_ST_IDLE;
            end
          end
          default:
            state_reg <= state_reg;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_data = `TMON_RST_ZERO;
    if (ptr_reg == `TMON_A_INT_TEMP)
      rd_data = res_int_reg;
    else if (ptr_reg == `TMON_A_EXT1_TEMP)
      rd_data = res_ext1_reg;
    else if (ptr_reg == `TMON_A_STATUS)
      rd_data = status_reg;
    else if (ptr_reg == `TMON_A_CONFIG || ptr_reg == `TMON_A_CONFIG_ALIAS)
      rd_data = ctrl_reg.general_config;
    else if (ptr_reg == `TMON_A_RATE || ptr_reg == `TMON_A_RATE_ALIAS)
      rd_data = ctrl_reg.update_rate;
    else if (ptr_reg == `TMON_A_INT_HI || ptr_reg == `TMON_A_INT_HI_ALIAS)
      rd_data = ctrl_reg.internal_high_limit;
    else if (ptr_reg == `TMON_A_INT_LO || ptr_reg == `TMON_A_INT_LO_ALIAS)
      rd_data = ctrl_reg.internal_low_limit;
    else if (ptr_reg == `TMON_A_E1_HI_INT || ptr_reg == `TMON_A_E1_HI_INT_ALIAS)
      rd_data = ctrl_reg.ext1_high_limit_integer;
    else if (ptr_reg == `TMON_A_E1_LO_INT || ptr_reg == `TMON_A_E1_LO_INT_ALIAS)
      rd_data = ctrl_reg.ext1_low_limit_integer;
    else if (ptr_reg == `TMON_A_EXT1_FRAC)
      rd_data = shadow_reg;
    else if (ptr_reg == `TMON_A_SCRATCH_A)
      rd_data = scratch_a_reg;
    else if (ptr_reg == `TMON_A_SCRATCH_B)
      rd_data = scratch_b_reg;
    else if (ptr_reg == `TMON_A_E1_HI_FRAC)
      rd_data = ctrl_reg.ext1_high_limit_fraction;
    else if (ptr_reg == `TMON_A_E1_LO_FRAC)
      rd_data = ctrl_reg.ext1_low_limit_fraction;
    else if (ptr_reg == `TMON_A_E2_HI_INT)
      rd_data = ctrl_reg.ext2_high_limit_integer;
    else if (ptr_reg == `TMON_A_E2_LO_INT)
      rd_data = ctrl_reg.ext2_low_limit_integer;
    else if (ptr_reg == `TMON_A_E2_HI_FRAC)
      rd_data = ctrl_reg.ext2_high_limit_fraction;
    else if (ptr_reg == `TMON_A_E2_LO_FRAC)
      rd_data = ctrl_reg.ext2_low_limit_fraction;
    else if (ptr_reg == `TMON_A_E1_CRIT)
      rd_data = ctrl_reg.ext1_critical_limit;
    else if (ptr_reg == `TMON_A_E2_CRIT)
      rd_data = ctrl_reg.ext2_critical_limit;
    else if (ptr_reg == `TMON_A_FAULT)
      rd_data = fault_reg;
    else if (ptr_reg == `TMON_A_MASK)
      rd_data = ctrl_reg.channel_masking;
  end

  // ---------------------------------------------------------------
  // Writable registers and the update trigger
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_reg <= '0;
      ctrl_reg.general_config <= `TMON_RST_CONFIG;
      ctrl_reg.update_rate <= `TMON_RST_RATE;
      ctrl_reg.internal_high_limit <= `TMON_RST_LIMIT_HI;
      ctrl_reg.ext1_high_limit_integer <= `TMON_RST_LIMIT_HI;
      ctrl_reg.ext2_high_limit_integer <= `TMON_RST_LIMIT_HI;
      ctrl_reg.ext1_critical_limit <= `TMON_RST_LIMIT_HI;
      ctrl_reg.ext2_critical_limit <= `TMON_RST_LIMIT_HI;
      scratch_a_reg <= `TMON_RST_ZERO;
      scratch_b_reg <= `TMON_RST_ZERO;
      one_update_reg <= 1'b0;
    end
    else if (ce)
    begin
      // Data byte is ignored, only the write itself counts
      one_update_reg <= wr_stb && ptr_reg == `TMON_A_ONE_UPDATE;
      if (wr_stb)
      begin
        if (ptr_reg == `TMON_A_CONFIG || ptr_reg == `TMON_A_CONFIG_ALIAS)
          ctrl_reg.general_config <= rx_reg;
        else if (ptr_reg == `TMON_A_RATE || ptr_reg == `TMON_A_RATE_ALIAS)
          ctrl_reg.update_rate <= rx_reg;
        else if (ptr_reg == `TMON_A_INT_HI || ptr_reg == `TMON_A_INT_HI_ALIAS)
          ctrl_reg.internal_high_limit <= rx_reg;
        else if (ptr_reg == `TMON_A_INT_LO || ptr_reg == `TMON_A_INT_LO_ALIAS)
          ctrl_reg.internal_low_limit <= rx_reg;
        else if (ptr_reg == `TMON_A_E1_HI_INT || ptr_reg == `TMON_A_E1_HI_INT_ALIAS)
          ctrl_reg.ext1_high_limit_integer <= rx_reg;
        else if (ptr_reg == `TMON_A_E1_LO_INT || ptr_reg == `TMON_A_E1_LO_INT_ALIAS)
          ctrl_reg.ext1_low_limit_integer <= rx_reg;
        else if (ptr_reg == `TMON_A_SCRATCH_A)
          scratch_a_reg <= rx_reg;
        else if (ptr_reg == `TMON_A_SCRATCH_B)
          scratch_b_reg <= rx_reg;
        else if (ptr_reg == `TMON_A_E1_HI_FRAC)
          ctrl_reg.ext1_high_limit_fraction <= rx_reg;
        else if (ptr_reg == `TMON_A_E1_LO_FRAC)
          ctrl_reg.ext1_low_limit_fraction <= rx_reg;
        else if (ptr_reg == `TMON_A_E2_HI_INT)
          ctrl_reg.ext2_high_limit_integer <= rx_reg;
        else if (ptr_reg == `TMON_A_E2_LO_INT)
          ctrl_reg.ext2_low_limit_integer <= rx_reg;
        else if (ptr_reg == `TMON_A_E2_HI_FRAC)
          ctrl_reg.ext2_high_limit_fraction <= rx_reg;
        else if (ptr_reg == `TMON_A_E2_LO_FRAC)
          ctrl_reg.ext2_low_limit_fraction <= rx_reg;
        else if (ptr_reg == `TMON_A_E1_CRIT)
          ctrl_reg.ext1_critical_limit <= rx_reg;
        else if (ptr_reg == `TMON_A_E2_CRIT)
          ctrl_reg.ext2_critical_limit <= rx_reg;
        else if (ptr_reg == `TMON_A_MASK)
          ctrl_reg.channel_masking <= rx_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Results, status, shadow and fault flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      res_int_reg <= `TMON_RST_ZERO;
      res_ext1_reg <= `TMON_RST_ZERO;
      res_frac_reg <= `TMON_RST_ZERO;
      shadow_reg <= `TMON_RST_ZERO;
      status_reg <= `TMON_RST_ZERO;
    end
    else if (ce)
    begin
      // Only the converter updates these; bus writes never reach them
      if (meas_i.valid)
      begin
        res_int_reg <= meas_i.int_temp[10:3];
        res_ext1_reg <= meas_i.ext1_temp[10:3];
        res_frac_reg <= {meas_i.ext1_temp[2:0], `TMON_FRAC_ZERO};
        status_reg <= meas_i.status & `TMON_STATUS_USED;
      end
      // Fraction is frozen so a later read matches the integer byte
      if (rd_stb && ptr_reg == `TMON_A_EXT1_TEMP)
        shadow_reg <= res_frac_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      fault_reg <= `TMON_RST_ZERO;
    else if (ce)
    begin
      // A fault arriving during the clearing read survives it
      if (rd_stb && ptr_reg == `TMON_A_FAULT)
        fault_reg <= meas_i.valid ? (meas_i.fault & `TMON_FAULT_USED) : `TMON_RST_ZERO;
      else if (meas_i.valid)
        fault_reg <= fault_reg | (meas_i.fault & `TMON_FAULT_USED);
    end
  end

  assign sda_o = sda_o_reg;
  assign sda_oe = sda_oe_reg;
  assign ctrl_o = ctrl_reg;
  assign one_update_o = one_update_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_config_alias: assert property (wr_stb && ptr_reg == `TMON_A_CONFIG_ALIAS |=>
    ctrl_reg.general_config == $past(rx_reg)) else $error("config alias write lost");
  a_rate_alias: assert property (wr_stb && ptr_reg == `TMON_A_RATE_ALIAS |=>
    ctrl_reg.update_rate == $past(rx_reg)) else $error("rate alias write lost");
  a_int_hi_alias: assert property (wr_stb && ptr_reg == `TMON_A_INT_HI_ALIAS |=>
    ctrl_reg.internal_high_limit == $past(rx_reg)) else $error("internal high alias lost");
  a_int_lo_alias: assert property (wr_stb && ptr_reg == `TMON_A_INT_LO_ALIAS |=>
    ctrl_reg.internal_low_limit == $past(rx_reg)) else $error("internal low alias lost");
  a_e1_hi_alias: assert property (wr_stb && ptr_reg == `TMON_A_E1_HI_INT_ALIAS |=>
    ctrl_reg.ext1_high_limit_integer == $past(rx_reg)) else $error("ext1 high alias lost");
  a_e1_lo_alias: assert property (wr_stb && ptr_reg == `TMON_A_E1_LO_INT_ALIAS |=>
    ctrl_reg.ext1_low_limit_integer == $past(rx_reg)) else $error("ext1 low alias lost");
  a_update_pulse: assert property (wr_stb && ptr_reg == `TMON_A_ONE_UPDATE |=>
    one_update_o ##1 (!one_update_o || $past(wr_stb))) else $error("update trigger not one pulse");
  a_fault_clear: assert property (rd_stb && ptr_reg == `TMON_A_FAULT && !meas_i.valid |=>
    fault_reg == `TMON_RST_ZERO) else $error("fault flags not cleared by read");
  a_unused_zero: assert property (res_frac_reg[4:0] == `TMON_FRAC_ZERO
    && (status_reg & ~`TMON_STATUS_USED) == `TMON_RST_ZERO) else $error("unused bits not zero");
  a_shadow_latch: assert property (rd_stb && ptr_reg == `TMON_A_EXT1_TEMP |=>
    shadow_reg == $past(res_frac_reg)) else $error("fraction shadow not latched");
  a_ro_kept: assert property (wr_stb && ptr_reg == `TMON_A_INT_TEMP && !meas_i.valid |=>
    $stable(res_int_reg) && $stable(status_reg)) else $error("read-only register changed");

endmodule

// [verification/tmon_host.sv]
// SMBus host model that drives the clock and data pins of the monitor
`timescale 1ns/1ps

module tmon_host
(
  input wire logic clk_sys, // System clock
  input wire logic sda_oe, // Device pull-low enable
  output logic scl_i, // Clock pin level
  output logic sda_i // Data pin level
);
  logic host_oe;

  initial
  begin
    host_oe = 1'b0;
    scl_i = 1'b1;
  end

  // Pull-up on the wire: a released line reads high
  assign sda_i = !(sda_oe | host_oe);

  // Quarter bit of 4 cycles keeps each clock phase at 8 cycles
  task qtr;
    repeat (4) @(negedge clk_sys);
  endtask

  task start_c;
    qtr;
    host_oe = 1'b0;
    qtr;
    scl_i = 1'b1;
    qtr;
    host_oe = 1'b1;
    qtr;
    scl_i = 1'b0;
  endtask

  task stop_c;
    qtr;
    host_oe = 1'b1;
    qtr;
    scl_i = 1'b1;
    qtr;
    host_oe = 1'b0;
    qtr;
  endtask

  // Eight bits MSB first, then the ninth bit; all sampled mid-high
  task xfer(input logic [7:0] d, input logic b9, output logic [7:0] r, output logic s9);
    logic [8:0] v;
    logic [8:0] q;
    v = {d, b9};
    for (int i = 8; i >= 0; i--)
    begin
      qtr;
      host_oe = !v[i];
      qtr;
      scl_i = 1'b1;
      qtr;
      q[i] = sda_i;
      qtr;
      scl_i = 1'b0;
    end
    r = q[8:1];
    s9 = q[0];
  endtask
endmodule

// [verification/tmon_regs_tb.sv]
// Self-checking bench for the temperature monitor register bank
`timescale 1ns/1ps

module tmon_regs_tb;
  logic clk_sys, nrst, ce, scl_i, sda_i, sda_o, sda_oe, one_update_o, a1;
  tmon_pkg::tmon_meas_t meas_i;
  tmon_pkg::tmon_ctrl_t ctrl_o;
  int fail_count, n_checks, n_pulse;
  logic [7:0] rd;
  // Row: address, reset value, write data, readback address, readback value
  logic [39:0] rows [29] = '{40'h0000ff0000, 40'h0100ff0100, 40'h0200ff0200, 40'h0380a509a5,
    40'h04065a0a5a, 40'h0555110b11, 40'h0600220c22, 40'h0755330d33, 40'h0800440e44,
    40'h09803c033c, 40'h0a06770477, 40'h0b55660566, 40'h0c00990699, 40'h0d55aa07aa,
    40'h0e00bb08bb, 40'h1000ff1000, 40'h1100c311c3, 40'h12003c123c, 40'h1300131313,
    40'h1400141414, 40'h1555151515, 40'h1600161616, 40'h1700171717, 40'h1800181818,
    40'h1955191919, 40'h1a551a1a1a, 40'h1b00ff1b00, 40'h1c00ff1c00, 40'h1f00e71fe7};

  tmon_regs u_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .meas_i(meas_i), .ctrl_o(ctrl_o), .one_update_o(one_update_o));
  tmon_host u_host (.clk_sys(clk_sys), .sda_oe(sda_oe), .scl_i(scl_i), .sda_i(sda_i));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
    if (one_update_o === 1'b1)
      n_pulse <= n_pulse + 1;

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task stop_test;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task ab(input logic [7:0] d);
    logic [7:0] r;
    logic a;
    u_host.xfer(d, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
  endtask

  task wr(input logic [7:0] p, input logic [7:0] d);
    u_host.start_c;
    ab(8'h54);
    ab(p);
    ab(d);
    u_host.stop_c;
  endtask

  // Host NACK ends the read after one byte
  task rdc(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] v;
    logic a;
    u_host.start_c;
    ab(8'h54);
    ab(p);
    u_host.start_c;
    ab(8'h55);
    u_host.xfer(8'hff, 1'b1, v, a);
    u_host.stop_c;
    chk(v, e);
  endtask

  task meas(input logic [10:0] it, input logic [10:0] et, input logic [7:0] st, input logic [7:0] ft);
    meas_i = '{1'b1, it, et, st, ft};
    @(negedge clk_sys);
    meas_i.valid = 1'b0;
  endtask

  // Hang guard
  initial
  begin
    repeat (99000) @(posedge clk_sys);
    fail_count++;
    stop_test;
  end

  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    meas_i = '0;
    fail_count = 0;
    n_checks = 0;
    n_pulse = 0;
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(ctrl_o.general_config, 8'h80);
    chk(ctrl_o.update_rate, 8'h06);
    chk({7'h00, sda_o}, 8'h00);
    foreach (rows[i])
      rdc(rows[i][39:32], rows[i][31:24]);
    foreach (rows[i])
    begin
      wr(rows[i][39:32], rows[i][23:16]);
      rdc(rows[i][15:8], rows[i][7:0]);
    end
    chk(ctrl_o.channel_masking, 8'he7);
    chk(n_pulse[7:0], 8'h00);
    wr(8'h0f, 8'h00);
    chk(n_pulse[7:0], 8'h01);
    rdc(8'h0f, 8'h00);
    meas(11'h2ab, 11'h3f5, 8'hff, 8'hff);
    rdc(8'h00, 8'h55);
    rdc(8'h02, 8'h9e);
    rdc(8'h01, 8'h7e);
    meas(11'h2ab, 11'h001, 8'h00, 8'h00);
    rdc(8'h10, 8'ha0);
    rdc(8'h01, 8'h00);
    rdc(8'h10, 8'h20);
    rdc(8'h1b, 8'h07);
    rdc(8'h1b, 8'h00);
    // Foreign slave address must be left unanswered
    u_host.start_c;
    u_host.xfer(8'h56, 1'b1, rd, a1);
    u_host.stop_c;
    chk({7'h00, a1}, 8'h01);
    wr(8'h11, 8'h5a);
    nrst = 1'b0;
    @(negedge clk_sys);
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rdc(8'h11, 8'h00);
    stop_test;
  end
endmodule
